/* pkg/ufa_pkg.sv */
// constants and types for the usb endpoint fifo access block
// Behaviour
// [RULE_01] port select 000-011 picks ports 2-5, 1xx port 1
// [RULE_02] sixteen test bits in two byte registers, reset zero
// [RULE_03] ep2 port direction follows endpoint direction setting
// [RULE_04] ep2 valid byte count, ten bits, read only
// [RULE_05] each data port access moves one byte
// [RULE_06] size register: ep1 code high, ep2 code low
// [RULE_07] code 0000 gives zero bytes, ep2 only
// [RULE_08] code 0100 gives sixteen bytes, reset 0x44
// [RULE_09] code 0101 gives thirty-two bytes, ep1 only
// [RULE_10] software writes no other size code
package ufa_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_TEST_UPPER = 16'hfdc1;
    localparam logic [15:0] IDX_TEST_LOWER = 16'hfdc2;
    localparam logic [15:0] IDX_EP2_COUNT_HIGH = 16'hfde2;
    localparam logic [15:0] IDX_EP2_COUNT_LOW = 16'hfde3;
    localparam logic [15:0] IDX_SIZE_CONFIG = 16'hfde4;
    localparam logic [15:0] IDX_EP2_DATA = 16'hfdd0;
    localparam logic [15:0] IDX_EP1_WRITE_DATA = 16'hfdd1;
    localparam logic [15:0] IDX_EP2_DIRECTION = 16'hfdd2;
    localparam logic [15:0] IDX_PORT_SELECT = 16'hfdd3;
    localparam logic [15:0] IDX_UNMAPPED = 16'h0000;

    // ahb-lite address split and transfer encodings
    localparam int ADDR_LSB = 2;
    localparam int ADDR_IDX_MSB = 17;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_SIZE_CONFIG = 8'h44;
    localparam logic [2:0] RST_PORT_SELECT = 3'h0;
    localparam logic RST_EP2_HOST_IN = 1'b0;

    // size configuration fields and codes
    localparam int EP1_SIZE_LSB = 4;
    localparam int EP2_SIZE_LSB = 0;
    localparam int SIZE_W = 4;
    localparam logic [3:0] SIZE_CODE_NONE = 4'h0;
    localparam logic [3:0] SIZE_CODE_16 = 4'h4;
    localparam logic [3:0] SIZE_CODE_32 = 4'h5;

    // fifo byte counts
    localparam int COUNT_W = 10;
    localparam int COUNT_HIGH_LSB = 8;
    localparam logic [9:0] SIZE_BYTES_NONE = 10'h000;
    localparam logic [9:0] SIZE_BYTES_16 = 10'h010;
    localparam logic [9:0] SIZE_BYTES_32 = 10'h020;
    localparam int FIFO_DEPTH = 32;

    // direction and port select fields
    localparam int DIR_HOST_IN_BIT = 0;
    localparam int PSEL_LSB = 0;
    localparam int PSEL_DEC_LSB = 4;
    localparam logic [2:0] PSEL_CODE_PORT2 = 3'h0;
    localparam logic [2:0] PSEL_CODE_PORT3 = 3'h1;
    localparam logic [2:0] PSEL_CODE_PORT4 = 3'h2;
    localparam logic [2:0] PSEL_CODE_PORT5 = 3'h3;
    localparam logic [2:0] DS_PORT1 = 3'h1;
    localparam logic [2:0] DS_PORT2 = 3'h2;
    localparam logic [2:0] DS_PORT3 = 3'h3;
    localparam logic [2:0] DS_PORT4 = 3'h4;
    localparam logic [2:0] DS_PORT5 = 3'h5;

    // one byte on a usb-side stream
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ufa_byte_stream_type;

    // a captured bus access
    typedef struct packed {
        logic [15:0] index;
        logic write;
    } ufa_access_type;

    // bus slave phase
    typedef enum logic [1:0] {
        ufa_idle = 2'b00,
        ufa_write = 2'b01,
        ufa_read_wait = 2'b10,
        ufa_read_done = 2'b11
    } ufa_phase_type;

endpackage

/* hw/ufa_byte_fifo.sv */
// byte fifo with a run-time capacity limit and a valid-byte count
`timescale 1ns/1ns
module ufa_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = ufa_pkg::FIFO_DEPTH,
    parameter int CW = ufa_pkg::COUNT_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic flush,
    input wire logic [CW-1:0] limit,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [CW-1:0] count
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic push;
    logic pop;

    // capacity is the smaller of the configured size and the array
    assign in_ready = (count < limit) && (count < CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage has no reset; only the pointers define content
    always_ff @(posedge hclk) begin
        if (clk_en && push && !flush) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and count; a flush drops everything held
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (clk_en) begin
            if (flush) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= '0;
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + PW'(1);
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + PW'(1);
                end
                if (push && !pop) begin
                    count <= count + CW'(1);
                end else if (pop && !push) begin
                    count <= count - CW'(1);
                end
            end
        end
    end

endmodule

/* hw/ufa_top.sv */
// usb endpoint fifo access: ahb-lite registers, ep1/ep2 fifos, port select
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ns
module ufa_top #(
    parameter int FIFO_DEPTH = ufa_pkg::FIFO_DEPTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire ufa_pkg::ufa_byte_stream_type usb_ep2_rx,
    output logic usb_ep2_rx_ready,
    output ufa_pkg::ufa_byte_stream_type usb_ep2_tx,
    input wire logic usb_ep2_tx_ready,
    output ufa_pkg::ufa_byte_stream_type usb_ep1_tx,
    input wire logic usb_ep1_tx_ready,
    output logic ep2_host_input,
    output logic [2:0] downstream_port
);

    // register state
    logic [7:0] usb_test_upper;
    logic [7:0] usb_test_lower;
    logic [7:0] endpoint_fifo_size_config;
    logic [2:0] port_select;
    ufa_pkg::ufa_phase_type phase;
    ufa_pkg::ufa_phase_type next_phase;
    ufa_pkg::ufa_access_type access;
    ufa_pkg::ufa_access_type next_access;

    // bus decode
    logic accept;
    logic addr_hit;
    logic commit_write;
    logic read_strobe;
    logic [7:0] wbyte;
    logic [31:0] next_rdata;

    // fifo wiring
    logic [ufa_pkg::COUNT_W-1:0] ep1_limit;
    logic [ufa_pkg::COUNT_W-1:0] ep2_limit;
    logic [ufa_pkg::COUNT_W-1:0] ep2_count;
    logic ep2_in_valid;
    logic [7:0] ep2_in_data;
    logic ep2_in_ready;
    logic ep2_out_valid;
    logic [7:0] ep2_out_data;
    logic ep2_out_ready;
    logic ep1_out_valid;
    logic [7:0] ep1_out_data;
    logic ep2_flush;
    logic cpu_ep2_push;
    logic cpu_ep2_pop;
    logic cpu_ep1_push;

    // size code to byte count; unlisted codes fall back to sixteen
    function automatic logic [ufa_pkg::COUNT_W-1:0] size_bytes(
        input logic [3:0] code
    );
        logic [ufa_pkg::COUNT_W-1:0] bytes;
        bytes = ufa_pkg::SIZE_BYTES_16; // [RULE_10]
        unique case (code)
            ufa_pkg::SIZE_CODE_NONE: bytes = ufa_pkg::SIZE_BYTES_NONE;
            ufa_pkg::SIZE_CODE_16: bytes = ufa_pkg::SIZE_BYTES_16;
            ufa_pkg::SIZE_CODE_32: bytes = ufa_pkg::SIZE_BYTES_32;
            default: bytes = ufa_pkg::SIZE_BYTES_16;
        endcase
        return bytes;
    endfunction

    // downstream port select decode
    function automatic logic [2:0] port_decode(input logic [2:0] code);
        logic [2:0] port;
        port = ufa_pkg::DS_PORT1;
        if (code[2]) begin
            port = ufa_pkg::DS_PORT1; // [RULE_01]
        end else begin
            unique case (code)
                ufa_pkg::PSEL_CODE_PORT2: port = ufa_pkg::DS_PORT2;
                ufa_pkg::PSEL_CODE_PORT3: port = ufa_pkg::DS_PORT3;
                ufa_pkg::PSEL_CODE_PORT4: port = ufa_pkg::DS_PORT4;
                ufa_pkg::PSEL_CODE_PORT5: port = ufa_pkg::DS_PORT5;
                default: port = ufa_pkg::DS_PORT1;
            endcase
        end
        return port;
    endfunction

    // address phase: only whole-word, aligned, in-window accesses hit
    assign addr_hit = (haddr[31:ufa_pkg::ADDR_IDX_MSB+1] == '0)
        && (haddr[ufa_pkg::ADDR_LSB-1:0] == '0)
        && (hsize == ufa_pkg::HSIZE_WORD);
    assign accept = hsel && hready && htrans[ufa_pkg::HTRANS_ACTIVE_BIT];
    assign wbyte = hwdata[7:0];

    // reads wait one cycle so a write just before is already stored
    assign hreadyout = clk_en && (phase != ufa_pkg::ufa_read_wait);
    assign hresp = ufa_pkg::HRESP_OKAY;
    assign commit_write = clk_en && (phase == ufa_pkg::ufa_write);
    assign read_strobe = clk_en && (phase == ufa_pkg::ufa_read_wait);

    // next phase and captured access
    always_comb begin
        next_phase = phase;
        next_access = access;
        if (phase == ufa_pkg::ufa_read_wait) begin
            next_phase = ufa_pkg::ufa_read_done;
        end else if (accept) begin
            next_access.write = hwrite;
            next_access.index = addr_hit
                ? haddr[ufa_pkg::ADDR_IDX_MSB:ufa_pkg::ADDR_LSB]
                : ufa_pkg::IDX_UNMAPPED;
            next_phase = hwrite ? ufa_pkg::ufa_write
                                : ufa_pkg::ufa_read_wait;
        end else begin
            next_phase = ufa_pkg::ufa_idle;
        end
    end

    // bus phase register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= ufa_pkg::ufa_idle;
            access <= '0;
        end else if (clk_en) begin
            phase <= next_phase;
            access <= next_access;
        end
    end

    // cpu side of the data ports; one byte per access
    assign cpu_ep2_push = commit_write
        && (access.index == ufa_pkg::IDX_EP2_DATA)
        && ep2_host_input; // [RULE_03] [RULE_05]
    assign cpu_ep2_pop = read_strobe
        && (access.index == ufa_pkg::IDX_EP2_DATA)
        && !ep2_host_input; // [RULE_03] [RULE_05]
    assign cpu_ep1_push = commit_write
        && (access.index == ufa_pkg::IDX_EP1_WRITE_DATA); // [RULE_05]

    // read data mux; write-only and unmapped words read zero
    always_comb begin
        next_rdata = '0;
        unique case (access.index)
            ufa_pkg::IDX_TEST_UPPER: next_rdata[7:0] = usb_test_upper;
            ufa_pkg::IDX_TEST_LOWER: next_rdata[7:0] = usb_test_lower;
            ufa_pkg::IDX_EP2_COUNT_HIGH: begin
                next_rdata[1:0] =
                    ep2_count[ufa_pkg::COUNT_W-1:ufa_pkg::COUNT_HIGH_LSB];
            end // [RULE_04]
            ufa_pkg::IDX_EP2_COUNT_LOW: begin
                next_rdata[7:0] =
                    ep2_count[ufa_pkg::COUNT_HIGH_LSB-1:0]; // [RULE_04]
            end
            ufa_pkg::IDX_SIZE_CONFIG: begin
                next_rdata[7:0] = endpoint_fifo_size_config; // [RULE_06]
            end
            ufa_pkg::IDX_EP2_DATA: begin
                if (cpu_ep2_pop && ep2_out_valid) begin
                    next_rdata[7:0] = ep2_out_data; // [RULE_05]
                end
            end
            ufa_pkg::IDX_EP2_DIRECTION: begin
                next_rdata[ufa_pkg::DIR_HOST_IN_BIT] = ep2_host_input;
            end
            ufa_pkg::IDX_PORT_SELECT: begin
                next_rdata[ufa_pkg::PSEL_LSB +: 3] = port_select;
                next_rdata[ufa_pkg::PSEL_DEC_LSB +: 3] = downstream_port;
            end
            default: next_rdata = '0;
        endcase
    end

    // read data flop, loaded in the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (read_strobe) begin
            hrdata <= next_rdata;
        end
    end

    // test register pair, plain storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            usb_test_upper <= ufa_pkg::RST_BYTE; // [RULE_02]
            usb_test_lower <= ufa_pkg::RST_BYTE; // [RULE_02]
        end else if (commit_write) begin
            if (access.index == ufa_pkg::IDX_TEST_UPPER) begin
                usb_test_upper <= wbyte; // [RULE_02]
            end
            if (access.index == ufa_pkg::IDX_TEST_LOWER) begin
                usb_test_lower <= wbyte; // [RULE_02]
            end
        end
    end

    // fifo size configuration; both fields reset to sixteen bytes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            endpoint_fifo_size_config <= ufa_pkg::RST_SIZE_CONFIG; // [RULE_08]
        end else if (commit_write
                     && access.index == ufa_pkg::IDX_SIZE_CONFIG) begin
            endpoint_fifo_size_config <= wbyte; // [RULE_06]
        end
    end

    // per-endpoint capacity from the size codes
    assign ep1_limit = size_bytes(
        endpoint_fifo_size_config[ufa_pkg::EP1_SIZE_LSB +: ufa_pkg::SIZE_W]
    ); // [RULE_07] [RULE_08] [RULE_09]
    assign ep2_limit = size_bytes(
        endpoint_fifo_size_config[ufa_pkg::EP2_SIZE_LSB +: ufa_pkg::SIZE_W]
    ); // [RULE_07] [RULE_08] [RULE_09]

    // endpoint 2 direction; a change empties the fifo so stale bytes
    // from the old direction never leave the wrong way
    assign ep2_flush = commit_write
        && (access.index == ufa_pkg::IDX_EP2_DIRECTION)
        && (wbyte[ufa_pkg::DIR_HOST_IN_BIT] != ep2_host_input);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ep2_host_input <= ufa_pkg::RST_EP2_HOST_IN;
        end else if (commit_write
                     && access.index == ufa_pkg::IDX_EP2_DIRECTION) begin
            ep2_host_input <= wbyte[ufa_pkg::DIR_HOST_IN_BIT]; // [RULE_03]
        end
    end

    // downstream port select and its decoded port number
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_select <= ufa_pkg::RST_PORT_SELECT;
            downstream_port <= ufa_pkg::DS_PORT2;
        end else if (clk_en) begin
            if (commit_write
                && access.index == ufa_pkg::IDX_PORT_SELECT) begin
                port_select <= wbyte[ufa_pkg::PSEL_LSB +: 3];
            end
            downstream_port <= port_decode(port_select); // [RULE_01]
        end
    end

    // endpoint 2 fifo steering: host input fills from the cpu and
    // drains to usb, host output fills from usb and drains to the cpu
    always_comb begin
        if (ep2_host_input) begin
            ep2_in_valid = cpu_ep2_push; // [RULE_03]
            ep2_in_data = wbyte;
            ep2_out_ready = usb_ep2_tx_ready;
        end else begin
            ep2_in_valid = usb_ep2_rx.valid; // [RULE_03]
            ep2_in_data = usb_ep2_rx.data;
            ep2_out_ready = cpu_ep2_pop;
        end
    end

    // usb side handshakes; the inactive direction stays quiet
    assign usb_ep2_rx_ready = !ep2_host_input && ep2_in_ready;
    assign usb_ep2_tx.valid = ep2_host_input && ep2_out_valid;
    assign usb_ep2_tx.data = ep2_out_data;
    assign usb_ep1_tx.valid = ep1_out_valid;
    assign usb_ep1_tx.data = ep1_out_data;

    // endpoint 2 fifo and its valid byte count
    ufa_byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .CW(ufa_pkg::COUNT_W)
    ) u_ep2_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .flush(ep2_flush),
        .limit(ep2_limit),
        .in_valid(ep2_in_valid),
        .in_data(ep2_in_data),
        .in_ready(ep2_in_ready),
        .out_valid(ep2_out_valid),
        .out_data(ep2_out_data),
        .out_ready(ep2_out_ready),
        .count(ep2_count)
    );

    // endpoint 1 fifo, host input only; count kept internal
    ufa_byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .CW(ufa_pkg::COUNT_W)
    ) u_ep1_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .flush(1'b0),
        .limit(ep1_limit),
        .in_valid(cpu_ep1_push),
        .in_data(wbyte),
        .in_ready(),
        .out_valid(ep1_out_valid),
        .out_data(ep1_out_data),
        .out_ready(usb_ep1_tx_ready),
        .count()
    );

endmodule

/* dv/ufa_top_properties.sv */
// assertion checker for the usb endpoint fifo access block
`timescale 1ns/1ns
module ufa_top_properties #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire ufa_pkg::ufa_byte_stream_type usb_ep2_rx,
    input wire logic usb_ep2_rx_ready,
    input wire ufa_pkg::ufa_byte_stream_type usb_ep2_tx,
    input wire logic usb_ep2_tx_ready,
    input wire ufa_pkg::ufa_byte_stream_type usb_ep1_tx,
    input wire logic usb_ep1_tx_ready,
    input wire logic ep2_host_input,
    input wire logic [2:0] downstream_port
);
    logic rd_take;
    logic wr_take;
    logic psel_dp;
    // requests as the slave takes them
    assign rd_take = hsel && hready && htrans[1] && !hwrite && clk_en;
    assign wr_take = hsel && hready && htrans[1] && hwrite && clk_en;
    // data phase of a port select write, so hwdata can be tied to it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psel_dp <= 1'h0;
        end else begin
            psel_dp <= wr_take && haddr[31:2] ==
                {14'h0000, ufa_pkg::IDX_PORT_SELECT};
        end
    end
    // expected port from the select code
    function automatic logic [2:0] port_of(input logic [2:0] code);
        return code[2] ? 3'h1 : {1'h0, code[1:0]} + 3'h2;
    endfunction
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_read_wait: assert property (
        rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read answer not after one wait state");
    a_write_nowait: assert property (
        wr_take |=> hreadyout)
        else $error("write data phase stalled");
    a_rdata_byte: assert property (
        hrdata[31:8] == 24'h00_0000)
        else $error("read data above bit 7 not zero");
    a_port_decode: assert property (
        psel_dp |-> ##2 downstream_port == port_of($past(hwdata[2:0], 2)))
        else $error("downstream port not decoded from code");
    a_port_reset: assert property (
        $rose(hresetn) |-> downstream_port == 3'h2)
        else $error("downstream port after reset not port 2");
    a_tx_dir: assert property (
        usb_ep2_tx.valid |-> ep2_host_input)
        else $error("ep2 offers bytes while host output");
    a_rx_dir: assert property (
        usb_ep2_rx_ready |-> !ep2_host_input)
        else $error("ep2 accepts bytes while host input");
    a_ep2_hold: assert property (
        usb_ep2_tx.valid && !usb_ep2_tx_ready |=>
        usb_ep2_tx.valid && $stable(usb_ep2_tx.data))
        else $error("ep2 byte withdrawn before taken");
    a_ep1_hold: assert property (
        usb_ep1_tx.valid && !usb_ep1_tx_ready |=>
        usb_ep1_tx.valid && $stable(usb_ep1_tx.data))
        else $error("ep1 byte withdrawn before taken");
endmodule
bind ufa_top ufa_top_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .usb_ep2_rx(usb_ep2_rx),
    .usb_ep2_rx_ready(usb_ep2_rx_ready), .usb_ep2_tx(usb_ep2_tx),
    .usb_ep2_tx_ready(usb_ep2_tx_ready), .usb_ep1_tx(usb_ep1_tx),
    .usb_ep1_tx_ready(usb_ep1_tx_ready), .ep2_host_input(ep2_host_input),
    .downstream_port(downstream_port)
);

/* dv/ufa_usb_host.sv */
// usb host model: feeds ep2 output bytes, drains ep1 and ep2 input bytes
`timescale 1ns/1ns
module ufa_usb_host (
    input wire logic hclk,
    input wire logic stall,
    input wire logic usb_ep2_rx_ready,
    output ufa_pkg::ufa_byte_stream_type usb_ep2_rx,
    output logic usb_ep2_tx_ready,
    output logic usb_ep1_tx_ready
);
    // idle at time zero
    initial begin
        usb_ep2_rx = 9'h000;
        usb_ep2_tx_ready = 1'h0;
        usb_ep1_tx_ready = 1'h0;
    end
    // random drain; the bench may hold both sinks off to fill fifos
    always @(posedge hclk) begin
        usb_ep2_tx_ready <= !stall && $urandom_range(1, 0) == 1;
        usb_ep1_tx_ready <= !stall && $urandom_range(1, 0) == 1;
    end
    // one byte held until taken, then the line shows the inverse
    task automatic send(input logic [7:0] d);
        @(posedge hclk);
        usb_ep2_rx <= {1'h1, d};
        do @(posedge hclk); while (usb_ep2_rx_ready !== 1'h1);
        usb_ep2_rx <= {1'h0, ~d};
    endtask
endmodule

/* dv/ufa_top_tb_top.sv */
// self-checking bench for the usb endpoint fifo access block
`timescale 1ns/1ns
module ufa_top_tb_top;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic clk_en = 1'h1;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic stall = 1'h1;
    logic rd_ph = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, usb_ep2_rx_ready, usb_ep2_tx_ready;
    logic usb_ep1_tx_ready, ep2_host_input;
    logic [31:0] hrdata;
    logic [2:0] downstream_port;
    ufa_pkg::ufa_byte_stream_type usb_ep2_rx, usb_ep2_tx, usb_ep1_tx;
    logic [7:0] exp_rd[$], exp_e1[$], exp_e2[$];
    logic [7:0] sent[16];
    logic [7:0] b;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;

    always #5 hclk = ~hclk;

    ufa_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .usb_ep2_rx(usb_ep2_rx), .usb_ep2_rx_ready(usb_ep2_rx_ready),
        .usb_ep2_tx(usb_ep2_tx), .usb_ep2_tx_ready(usb_ep2_tx_ready),
        .usb_ep1_tx(usb_ep1_tx), .usb_ep1_tx_ready(usb_ep1_tx_ready),
        .ep2_host_input(ep2_host_input),
        .downstream_port(downstream_port));

    ufa_usb_host host (.hclk(hclk), .stall(stall),
        .usb_ep2_rx_ready(usb_ep2_rx_ready), .usb_ep2_rx(usb_ep2_rx),
        .usb_ep2_tx_ready(usb_ep2_tx_ready),
        .usb_ep1_tx_ready(usb_ep1_tx_ready));

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one single ahb-lite transfer; waits on hready, never on a count
    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {14'h0000, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge hclk); while (hreadyout !== 1'h1);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'h1, idx, d);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        exp_rd.push_back(e);
        bus(1'h0, idx, 8'h00);
    endtask

    // compares each read answer and each byte the host takes
    always @(posedge hclk) begin
        if (rd_ph && hreadyout) begin
            rd_ph <= 1'h0;
            chk("read data", {24'h00_0000, exp_rd.pop_front()}, hrdata);
            chk("hresp", 32'h0, 32'(hresp));
        end else if (hsel && htrans[1] && !hwrite && hreadyout) begin
            rd_ph <= 1'h1;
        end
        if (usb_ep1_tx.valid && usb_ep1_tx_ready) begin
            chk("ep1 byte", 32'(exp_e1.pop_front()), 32'(usb_ep1_tx.data));
        end
        if (usb_ep2_tx.valid && usb_ep2_tx_ready) begin
            chk("ep2 byte", 32'(exp_e2.pop_front()), 32'(usb_ep2_tx.data));
        end
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        void'($urandom(32'hb395));
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        rd(ufa_pkg::IDX_TEST_UPPER, 8'h00); // reset zero
        rd(ufa_pkg::IDX_TEST_LOWER, 8'h00); // reset zero
        rd(ufa_pkg::IDX_EP2_COUNT_HIGH, 8'h00); // empty
        rd(ufa_pkg::IDX_SIZE_CONFIG, 8'h44); // sixteen each
        b = 8'($urandom);
        wr(ufa_pkg::IDX_TEST_UPPER, b);
        wr(ufa_pkg::IDX_TEST_LOWER, ~b);
        rd(ufa_pkg::IDX_TEST_UPPER, b); // bits 15:8
        rd(ufa_pkg::IDX_TEST_LOWER, ~b); // bits 7:0
        wr(ufa_pkg::IDX_EP2_COUNT_LOW, 8'hff);
        rd(ufa_pkg::IDX_EP2_COUNT_LOW, 8'h00); // read only
        rd(ufa_pkg::IDX_UNMAPPED, 8'h00);
        // every select code, decoded port checked two cycles after the store
        for (int c = 0; c < 8; c++) begin
            wr(ufa_pkg::IDX_PORT_SELECT, 8'(c));
            repeat (2) @(posedge hclk);
            chk("port", c > 3 ? 32'h1 : 32'(c + 2),
                32'(downstream_port));
        end
        // host output into ep2 until its sixteen bytes are full
        for (int i = 0; i < 16; i++) begin
            sent[i] = 8'($urandom);
            host.send(sent[i]);
        end
        repeat (2) @(posedge hclk);
        chk("rx ready full", 32'h0, 32'(usb_ep2_rx_ready));
        rd(ufa_pkg::IDX_EP2_COUNT_LOW, 8'h10); // sixteen held
        rd(ufa_pkg::IDX_EP2_COUNT_HIGH, 8'h00); // high bits
        for (int i = 0; i < 16; i++) begin
            rd(ufa_pkg::IDX_EP2_DATA, sent[i]); // one pop each
        end
        rd(ufa_pkg::IDX_EP2_DATA, 8'h00);
        wr(ufa_pkg::IDX_EP2_DATA, 8'h5a);
        rd(ufa_pkg::IDX_EP2_COUNT_LOW, 8'h00); // write ignored
        wr(ufa_pkg::IDX_SIZE_CONFIG, 8'h50); // legal codes only
        rd(ufa_pkg::IDX_SIZE_CONFIG, 8'h50); // both fields
        @(posedge hclk);
        chk("rx ready none", 32'h0, 32'(usb_ep2_rx_ready));
        // ep1 at thirty-two bytes with the host stalled: last one drops
        for (int i = 0; i < 33; i++) begin
            b = 8'($urandom);
            if (i < 32) begin
                exp_e1.push_back(b);
            end
            wr(ufa_pkg::IDX_EP1_WRITE_DATA, b); // capacity
        end
        wr(ufa_pkg::IDX_SIZE_CONFIG, 8'h54); // legal codes only
        wr(ufa_pkg::IDX_EP2_DIRECTION, 8'h01);
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom);
            exp_e2.push_back(b);
            wr(ufa_pkg::IDX_EP2_DATA, b); // cpu push
        end
        rd(ufa_pkg::IDX_EP2_COUNT_LOW, 8'h03); // three held
        rd(ufa_pkg::IDX_EP2_DATA, 8'h00); // read refused
        chk("direction", 32'h1, 32'(ep2_host_input));
        stall <= 1'h0;
        for (int i = 0; i < 2000 && exp_e1.size() + exp_e2.size() > 0;
             i++) begin
            @(posedge hclk);
        end
        chk("bytes left", 32'h0,
            32'(exp_e1.size() + exp_e2.size()));
        close_out();
    end
endmodule
